// ### src/capture_compare_unit.sv
// capture/compare unit: two time bases, sixteen channels, AXI4-Lite slave
`timescale 1ns/1ns
module capture_compare_unit (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register bus
    input wire cc_pkg::axi_req_t bus_req,
    output cc_pkg::axi_rsp_t bus_rsp,
    // count sources from outside the unit
    input wire logic aux_gp_timer_ovf,
    input wire logic ext_count,
    // channel pins
    input wire logic [15:0] cc_pin_in,
    output logic [15:0] cc_pin_out,
    output logic [15:0] cc_pin_oe,
    // interrupt
    output logic irq,
    output logic [7:0] irq_vector,
    output logic [7:0] irq_trap
);
    cc_pkg::state_t r, n;
    logic [1:0] tick, ovf;
    logic [1:0][15:0] cnt_nx;
    logic [15:0] match, edge_ok, tog;
    logic [17:0] set_req, clr_req;
    logic aw_hs, w_hs, ar_hs, wr_go, ext_rise;
    logic [31:0] wv, wm;
    logic [7:0] wa;

    // offsets that answer OKAY
    function automatic logic mapped(input logic [7:0] a);
        if (a[7:6] == cc_pkg::A_CFG_PG || a[7:6] == cc_pkg::A_VAL_PG) begin
            return 1'b1;
        end else begin
            return a[7:2] <= cc_pkg::A_DBL[7:2];
        end
    endfunction: mapped

    // register read view, unmapped reads as zero
    function automatic logic [31:0] rd_word(input cc_pkg::state_t s, input logic [7:0] a);
        logic [31:0] d;
        logic [7:0] w;
        d = '0;
        w = {a[7:2], 2'b00};
        if (a[7:6] == cc_pkg::A_CFG_PG) begin
            d[3:0] = s.cfg[a[5:2]];
        end else if (a[7:6] == cc_pkg::A_VAL_PG) begin
            d[15:0] = s.val[a[5:2]];
        end else if (w == cc_pkg::A_TBCTL) begin
            d[7:0] = s.tb_ctl;
        end else if (w == cc_pkg::A_CNT_A) begin
            d[15:0] = s.tcnt[0];
        end else if (w == cc_pkg::A_REL_A) begin
            d[15:0] = s.trel[0];
        end else if (w == cc_pkg::A_CNT_B) begin
            d[15:0] = s.tcnt[1];
        end else if (w == cc_pkg::A_REL_B) begin
            d[15:0] = s.trel[1];
        end else if (w == cc_pkg::A_REQ) begin
            d[17:0] = s.req;
        end else if (w == cc_pkg::A_EN) begin
            d[17:0] = s.en;
        end else if (w == cc_pkg::A_VEC) begin
            d[16:0] = {s.irq, s.trap, s.vec};
        end else if (w == cc_pkg::A_DBL) begin
            d[7:0] = s.dbl;
        end
        return d;
    endfunction: rd_word

    // byte-lane merge under write strobes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                o[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return o;
    endfunction: merge

    // count tick for one time base
    function automatic logic tick_of(input logic [2:0] sel, input logic [6:0] pre,
                                     input logic aux, input logic ext);
        logic [6:0] m;
        m = 7'((cc_pkg::PRE_CYC << sel[1:0]) - 1);
        if (sel == 3'(cc_pkg::CK_AUX)) begin
            return aux;
        end else if (sel == 3'(cc_pkg::CK_EXT)) begin
            return ext;
        end else if (sel > 3'(cc_pkg::CK_EXT)) begin
            return 1'b0;
        end else begin
            return (pre & m) == m;
        end
    endfunction: tick_of

    // whole next state
    always_comb begin
        n = r;
        tick = '0;
        ovf = '0;
        cnt_nx = r.tcnt;
        match = '0;
        edge_ok = '0;
        tog = '0;
        set_req = '0;
        clr_req = '0;
        wa = {r.awaddr[7:2], 2'b00};
        wm = merge(32'h0, 32'hFFFFFFFF, r.wstrb);
        wv = merge(rd_word(r, r.awaddr), r.wdata, r.wstrb);
        aw_hs = bus_req.awvalid && !r.aw_got && !r.bvalid;
        w_hs = bus_req.wvalid && !r.w_got && !r.bvalid;
        ar_hs = bus_req.arvalid && !r.rvalid;
        wr_go = r.aw_got && r.w_got;
        ext_rise = ext_count && !r.ext_q;
        n.ext_q = ext_count;
        n.pre = r.pre + 7'h01; // R16
        n.pin_q = cc_pin_in;

        // time bases: tick, overflow, reload
        for (int t = 0; t < 2; t++) begin
            tick[t] = r.tb_ctl[t*cc_pkg::TBF_W + cc_pkg::TBF_RUN]
                && tick_of(r.tb_ctl[t*cc_pkg::TBF_W +: 3], r.pre, aux_gp_timer_ovf,
                           (t == 0) && ext_rise); // R1 R2 R3
            if (tick[t]) begin
                ovf[t] = r.tcnt[t] == cc_pkg::CNT_MAX;
                cnt_nx[t] = ovf[t] ? r.trel[t] : r.tcnt[t] + cc_pkg::CNT_ONE; // R17
            end
            n.tcnt[t] = cnt_nx[t];
            set_req[cc_pkg::NCH + t] = ovf[t]; // R15 R18
        end

        // write channel; software wins over a tick on the timers
        if (aw_hs) begin
            n.aw_got = 1'b1;
            n.awaddr = bus_req.awaddr;
        end
        if (w_hs) begin
            n.w_got = 1'b1;
            n.wdata = bus_req.wdata;
            n.wstrb = bus_req.wstrb;
        end
        if (wr_go) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = mapped(r.awaddr) ? cc_pkg::RESP_OK : cc_pkg::RESP_ERR;
            if (r.awaddr[7:6] == cc_pkg::A_CFG_PG) begin
                n.cfg[r.awaddr[5:2]] = wv[3:0]; // R4
            end else if (r.awaddr[7:6] == cc_pkg::A_VAL_PG) begin
                n.val[r.awaddr[5:2]] = wv[15:0];
            end else if (wa == cc_pkg::A_TBCTL) begin
                n.tb_ctl = wv[7:0];
            end else if (wa == cc_pkg::A_CNT_A) begin
                n.tcnt[0] = wv[15:0];
            end else if (wa == cc_pkg::A_REL_A) begin
                n.trel[0] = wv[15:0];
            end else if (wa == cc_pkg::A_CNT_B) begin
                n.tcnt[1] = wv[15:0];
            end else if (wa == cc_pkg::A_REL_B) begin
                n.trel[1] = wv[15:0];
            end else if (wa == cc_pkg::A_REQ) begin
                clr_req = r.wdata[17:0] & wm[17:0]; // R18
            end else if (wa == cc_pkg::A_EN) begin
                n.en = wv[17:0];
            end else if (wa == cc_pkg::A_DBL) begin
                n.dbl = wv[7:0];
            end
        end else if (r.bvalid && bus_req.bready) begin
            n.bvalid = 1'b0;
        end

        // read channel, answer one cycle after the address is taken
        if (ar_hs) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word(r, bus_req.araddr);
            n.rresp = mapped(bus_req.araddr) ? cc_pkg::RESP_OK : cc_pkg::RESP_ERR;
        end else if (r.rvalid && bus_req.rready) begin
            n.rvalid = 1'b0;
        end

        // channels; a capture wins over a software write of the value
        for (int i = 0; i < cc_pkg::NCH; i++) begin
            case (r.cfg[i].mode)
                cc_pkg::CAP_RISE: edge_ok[i] = cc_pin_in[i] && !r.pin_q[i]; // R7
                cc_pkg::CAP_FALL: edge_ok[i] = !cc_pin_in[i] && r.pin_q[i]; // R7
                cc_pkg::CAP_BOTH: edge_ok[i] = cc_pin_in[i] != r.pin_q[i]; // R7
                default: edge_ok[i] = 1'b0;
            endcase
            match[i] = r.cfg[i].mode >= cc_pkg::CMP0 && tick[r.cfg[i].tsel]
                && cnt_nx[r.cfg[i].tsel] == r.val[i]; // R8
            if (edge_ok[i]) begin
                n.val[i] = r.tcnt[r.cfg[i].tsel]; // R6
                set_req[i] = 1'b1; // R6
            end
            // overflow opens a new period before a match in the same cycle
            if (ovf[r.cfg[i].tsel]) begin
                n.done[i] = 1'b0; // R11
                if (r.cfg[i].mode == cc_pkg::CMP3) begin
                    n.pin[i] = 1'b0; // R12
                end
            end
            if (match[i] && r.dbl[i % cc_pkg::NPAIR]) begin
                set_req[i] = 1'b1;
                tog[i % cc_pkg::NPAIR] = 1'b1; // R13
            end else if (match[i]) begin
                case (r.cfg[i].mode)
                    cc_pkg::CMP0: set_req[i] = 1'b1; // R9
                    cc_pkg::CMP1: begin
                        set_req[i] = 1'b1;
                        tog[i] = 1'b1; // R10
                    end
                    default: begin
                        if (!r.done[i] || ovf[r.cfg[i].tsel]) begin
                            set_req[i] = 1'b1; // R11
                            n.done[i] = 1'b1;
                            if (r.cfg[i].mode == cc_pkg::CMP3) begin
                                n.pin[i] = 1'b1; // R12
                            end
                        end
                    end
                endcase
            end
        end
        n.pin = n.pin ^ tog; // R5

        // pin direction follows function; the upper half of a pair gives its pin away
        for (int i = 0; i < cc_pkg::NCH; i++) begin
            if (i < cc_pkg::NPAIR) begin
                n.oe[i] = n.cfg[i].mode inside {cc_pkg::CMP1, cc_pkg::CMP3}
                    || n.dbl[i % cc_pkg::NPAIR]; // R5
            end else begin
                n.oe[i] = n.cfg[i].mode inside {cc_pkg::CMP1, cc_pkg::CMP3}
                    && !n.dbl[i % cc_pkg::NPAIR]; // R13
            end
        end

        // sticky flags: a set in the clearing cycle wins
        n.req = (r.req & ~clr_req) | set_req; // R18
        n.irq = |(n.req & n.en); // R17
        n.vec = '0;
        n.trap = '0;
        // lowest source index has priority
        for (int s = cc_pkg::NSRC - 1; s >= 0; s--) begin
            if (n.req[s] && n.en[s]) begin
                n.vec = 8'(cc_pkg::VEC_BASE + 8'(s) * cc_pkg::VEC_STEP); // R14 R15
                n.trap = 8'(cc_pkg::TRAP_BASE + 8'(s)); // R14 R15
            end
        end
    end

    // single state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= cc_pkg::ST_RST;
        end else begin
            r <= n;
        end
    end

    // outputs; ready terms are combinational
    always_comb begin
        bus_rsp.awready = !r.aw_got && !r.bvalid;
        bus_rsp.wready = !r.w_got && !r.bvalid;
        bus_rsp.bvalid = r.bvalid;
        bus_rsp.bresp = r.bresp;
        bus_rsp.arready = !r.rvalid;
        bus_rsp.rvalid = r.rvalid;
        bus_rsp.rdata = r.rdata;
        bus_rsp.rresp = r.rresp;
        cc_pin_out = r.pin;
        cc_pin_oe = r.oe;
        irq = r.irq;
        irq_vector = r.vec;
        irq_trap = r.trap;
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_res;
        (tick[0] && r.tb_ctl[3:0] == {1'b1, cc_pkg::CK_DIV1}) |=> !tick[0] [*7];
    endproperty
    a_res: assert property (p_res) else $error("fastest tick closer than 400 ns"); // R16

    property p_reload;
        (ovf[0] && !wr_go) |=> r.tcnt[0] == $past(r.trel[0]);
    endproperty
    a_reload: assert property (p_reload) else $error("overflow did not reload"); // R17

    property p_ovf_req;
        ovf[1] |=> r.req[17];
    endproperty
    a_ovf_req: assert property (p_ovf_req) else $error("timer request not set"); // R18

    property p_sticky;
        (r.req[0] && !(wr_go && wa == cc_pkg::A_REQ)) |=> r.req[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("request dropped by itself"); // R18

    property p_capture;
        edge_ok[0] |=> r.val[0] == $past(r.tcnt[r.cfg[0].tsel]) && r.req[0];
    endproperty
    a_capture: assert property (p_capture) else $error("capture value or request lost"); // R6

    property p_toggle;
        (match[0] && r.cfg[0].mode == cc_pkg::CMP1 && !r.dbl[0])
            |=> cc_pin_out[0] != $past(cc_pin_out[0]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("pin did not toggle"); // R10

    property p_mode3;
        (ovf[0] && !r.cfg[0].tsel && r.cfg[0].mode == cc_pkg::CMP3 && !match[0])
            |=> !cc_pin_out[0];
    endproperty
    a_mode3: assert property (p_mode3) else $error("pin not low after overflow"); // R12

    property p_once;
        (match[6] && r.done[6] && r.cfg[6].mode == cc_pkg::CMP2 && !r.dbl[6]
            && !ovf[r.cfg[6].tsel] && !r.req[6]) |=> !r.req[6];
    endproperty
    a_once: assert property (p_once) else $error("second request in one period"); // R11

    property p_vec;
        (irq && r.req[0] && r.en[0])
            |-> irq_vector == cc_pkg::VEC_BASE && irq_trap == cc_pkg::TRAP_BASE;
    endproperty
    a_vec: assert property (p_vec) else $error("wrong vector for channel 0"); // R14

    property p_irq;
        (r.req[16] && r.en[16] && !wr_go) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("enabled request not forwarded"); // R17

    c_cap: cover property (edge_ok[0] ##1 r.req[0]);
    c_tog: cover property (match[0] && r.cfg[0].mode == cc_pkg::CMP1);
    c_dbl: cover property (match[8] && r.dbl[0]);
    c_irq: cover property ($rose(irq));
endmodule: capture_compare_unit

// ### src/cc_pkg.sv
// constants, types and register map of the capture/compare unit
// Summary of operation
// R1 - two 16-bit time bases, each with reload
// R2 - time base clock: prescaler or aux timer overflow
// R3 - first time base may count external edges
// R4 - sixteen channels, per-channel timer and function
// R5 - one pin per channel, input or output
// R6 - capture copies timer count, sets request
// R7 - capture on rising, falling or both edges
// R8 - compare channels match their assigned timer
// R9 - compare mode zero: request on every match
// R10 - compare mode one: pin toggles every match
// R11 - compare mode two: one request per period
// R12 - mode three: set on match, clear on overflow
// R13 - double register: two channels toggle one pin
// R14 - channel vectors 40h-7Ch, traps 10h-1Fh
// R15 - timer vectors 80h/84h, traps 20h/21h
// R16 - finest resolution 400 ns prescaler step
// R17 - overflow reloads; request forwarded when enabled
// R18 - requests sticky until cleared, set regardless
package cc_pkg;
    localparam int NCH = 16;
    localparam int NSRC = 18;
    localparam int NPAIR = 8;
    localparam int CLK_NS = 50;
    localparam int RES_NS = 400;
    // finest tick in whole cycles, rounded up
    localparam int PRE_CYC = (RES_NS + CLK_NS - 1) / CLK_NS;
    localparam int PRE_W = 7;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    // vector and trap numbering, source index order
    localparam logic [7:0] VEC_BASE = 8'h40;
    localparam logic [7:0] VEC_STEP = 8'h04;
    localparam logic [7:0] TRAP_BASE = 8'h10;
    // register byte offsets
    localparam logic [7:0] A_TBCTL = 8'h00;
    localparam logic [7:0] A_CNT_A = 8'h04;
    localparam logic [7:0] A_REL_A = 8'h08;
    localparam logic [7:0] A_CNT_B = 8'h0C;
    localparam logic [7:0] A_REL_B = 8'h10;
    localparam logic [7:0] A_REQ = 8'h14;
    localparam logic [7:0] A_EN = 8'h18;
    localparam logic [7:0] A_VEC = 8'h1C;
    localparam logic [7:0] A_DBL = 8'h20;
    // channel config page 0x40, channel value page 0x80
    localparam logic [1:0] A_CFG_PG = 2'h1;
    localparam logic [1:0] A_VAL_PG = 2'h2;
    // time base control: 4 bits per timer
    localparam int TBF_W = 4;
    localparam int TBF_RUN = 3;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    typedef enum logic [2:0] {CK_DIV1, CK_DIV2, CK_DIV4, CK_DIV8, CK_AUX, CK_EXT} clk_sel_t;
    typedef enum logic [2:0] {
        CH_OFF, CAP_RISE, CAP_FALL, CAP_BOTH, CMP0, CMP1, CMP2, CMP3
    } ch_mode_t;
    typedef struct packed {
        logic tsel;
        ch_mode_t mode;
    } ch_cfg_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_t;

    typedef struct packed {
        logic [7:0] tb_ctl;
        logic [1:0][15:0] tcnt;
        logic [1:0][15:0] trel;
        logic [PRE_W-1:0] pre;
        logic ext_q;
        ch_cfg_t [NCH-1:0] cfg;
        logic [NCH-1:0][15:0] val;
        logic [NCH-1:0] pin_q;
        logic [NCH-1:0] pin;
        logic [NCH-1:0] oe;
        logic [NCH-1:0] done;
        logic [NPAIR-1:0] dbl;
        logic [NSRC-1:0] req;
        logic [NSRC-1:0] en;
        logic irq;
        logic [7:0] vec;
        logic [7:0] trap;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;
    localparam state_t ST_RST = '0;
endpackage: cc_pkg

// ### sim/cc_pin_model.sv
// far-side model: channel pins, auxiliary overflow and external count source
`timescale 1ns/1ns
module cc_pin_model (
    // clock
    input wire logic ref_clk,
    // pins from the unit
    input wire logic [15:0] cc_pin_out,
    input wire logic [15:0] cc_pin_oe,
    // sources into the unit
    output logic [15:0] cc_pin_in,
    output logic aux_gp_timer_ovf,
    output logic ext_count
);
    logic [15:0] drive_lvl_r;

    // wire level: the unit wins where it drives, else our own level
    assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drive_lvl_r);

    initial begin
        drive_lvl_r = 16'h0000;
        aux_gp_timer_ovf = 1'b0;
        ext_count = 1'b0;
    end

    // one pin transition, held well past the unit's edge detector
    task automatic set_pin(input int ch, input logic v);
        @(posedge ref_clk);
        drive_lvl_r[ch] <= v;
        repeat (3) @(posedge ref_clk);
    endtask: set_pin

    // one-cycle overflow pulse of the auxiliary timer
    task automatic aux_pulse();
        @(posedge ref_clk);
        aux_gp_timer_ovf <= 1'b1;
        @(posedge ref_clk);
        aux_gp_timer_ovf <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask: aux_pulse

    // one external count edge; low time gives the detector a clean edge
    task automatic ext_pulse();
        @(posedge ref_clk);
        ext_count <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ext_count <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask: ext_pulse
endmodule: cc_pin_model

// ### sim/sixteen_channel_capture_compare_tb_top.sv
// testbench: register-level tests of the capture/compare unit
`timescale 1ns/1ns
module sixteen_channel_capture_compare_tb_top;
    logic ref_clk;
    logic rst;
    cc_pkg::axi_req_t bus_req;
    cc_pkg::axi_rsp_t bus_rsp;
    logic aux_gp_timer_ovf, ext_count, irq;
    logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe;
    logic [7:0] irq_vector, irq_trap;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] d, d2, d3, d4;
    logic [1:0] r;
    int cmp_ch [6] = '{0, 1, 6, 7, 2, 10};
    cc_pkg::ch_mode_t cmp_md [6] = '{cc_pkg::CMP0, cc_pkg::CMP1, cc_pkg::CMP2,
        cc_pkg::CMP3, cc_pkg::CMP1, cc_pkg::CMP1};

    capture_compare_unit dut_u (
        .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
        .aux_gp_timer_ovf(aux_gp_timer_ovf), .ext_count(ext_count),
        .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
        .irq(irq), .irq_vector(irq_vector), .irq_trap(irq_trap)
    );
    cc_pin_model pins_u (
        .ref_clk(ref_clk), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
        .cc_pin_in(cc_pin_in), .aux_gp_timer_ovf(aux_gp_timer_ovf), .ext_count(ext_count)
    );

    // 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask: give_verdict

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask: chk32

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask: chk1

    // write: both channels offered together, each dropped once taken
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
        int n;
        logic aw_ok;
        logic w_ok;
        @(posedge ref_clk);
        bus_req.awaddr <= a;
        bus_req.wdata <= dat;
        bus_req.wstrb <= 4'hF;
        bus_req.awvalid <= 1'b1;
        bus_req.wvalid <= 1'b1;
        bus_req.bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (!aw_ok && bus_rsp.awready) begin
                aw_ok = 1'b1;
                bus_req.awvalid <= 1'b0;
            end
            if (!w_ok && bus_rsp.wready) begin
                w_ok = 1'b1;
                bus_req.wvalid <= 1'b0;
            end
        end while (!(aw_ok && w_ok && bus_rsp.bvalid) && n < 500);
        bus_req.bready <= 1'b0;
        rs = bus_rsp.bresp;
        if (n >= 500) chk1(1'b0, 1'b1);
    endtask: bus_wr

    // read: address held until taken, rready held until data arrives
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
        int n;
        logic ar_ok;
        @(posedge ref_clk);
        bus_req.araddr <= a;
        bus_req.arvalid <= 1'b1;
        bus_req.rready <= 1'b1;
        ar_ok = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (!ar_ok && bus_rsp.arready) begin
                ar_ok = 1'b1;
                bus_req.arvalid <= 1'b0;
            end
        end while (!(ar_ok && bus_rsp.rvalid) && n < 500);
        bus_req.rready <= 1'b0;
        dat = bus_rsp.rdata;
        rs = bus_rsp.rresp;
        if (n >= 500) chk1(1'b0, 1'b1);
    endtask: bus_rd

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        logic [1:0] rs;
        bus_wr(a, dat, rs);
        chk32(32'(rs), 32'(cc_pkg::RESP_OK));
    endtask: wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dat;
        logic [1:0] rs;
        bus_rd(a, dat, rs);
        chk32(dat, exp);
    endtask: rd_chk

    function automatic logic [7:0] cfg_a(input int i);
        return {cc_pkg::A_CFG_PG, 4'(i), 2'h0};
    endfunction: cfg_a

    function automatic logic [7:0] val_a(input int i);
        return {cc_pkg::A_VAL_PG, 4'(i), 2'h0};
    endfunction: val_a

    // load time base a, move one pin, read the channel's value back
    task automatic cap_step(input int ch, input logic [15:0] cnt, input logic v,
        input logic [15:0] exp);
        wr(cc_pkg::A_CNT_A, {16'h0, cnt});
        pins_u.set_pin(ch, v);
        rd_chk(val_a(ch), {16'h0, exp});
    endtask: cap_step

    // watchdog: the whole sequence needs a little over a thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        bus_req = '0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // reset state and unmapped places
        rd_chk(cc_pkg::A_REQ, 32'h0);
        chk1(irq, 1'b0);
        bus_rd(8'h24, d, r);
        chk32({d[31:2], r}, {30'h0, cc_pkg::RESP_ERR});
        bus_wr(8'hC0, 32'hFFFFFFFF, r);
        chk32(32'(r), 32'(cc_pkg::RESP_ERR));
        // time base a on external edges, time base b on aux overflows
        wr(cc_pkg::A_TBCTL, 32'hCD);
        wr(cc_pkg::A_REL_A, 32'h1234);
        wr(cc_pkg::A_CNT_A, 32'hFFFE);
        pins_u.ext_pulse();
        rd_chk(cc_pkg::A_CNT_A, 32'hFFFF);
        pins_u.ext_pulse();
        rd_chk(cc_pkg::A_CNT_A, 32'h1234);
        rd_chk(cc_pkg::A_REQ, 32'h10000);
        chk1(irq, 1'b0);
        wr(cc_pkg::A_EN, 32'h10000);
        rd_chk(cc_pkg::A_VEC, 32'h12080);
        chk1(irq, 1'b1);
        wr(cc_pkg::A_REQ, 32'h10000);
        chk1(irq, 1'b0);
        wr(cc_pkg::A_REL_B, 32'h7);
        wr(cc_pkg::A_CNT_B, 32'hFFFE);
        pins_u.aux_pulse();
        pins_u.aux_pulse();
        rd_chk(cc_pkg::A_CNT_B, 32'h7);
        wr(cc_pkg::A_EN, 32'h20000);
        rd_chk(cc_pkg::A_VEC, 32'h12184);
        chk32({16'h0, irq_trap, irq_vector}, 32'h2184);
        wr(cc_pkg::A_EN, 32'h0);
        // every channel captures on both edges and owns its vector
        for (int i = 0; i < 16; i++) begin
            wr(cfg_a(i), 32'(cc_pkg::CAP_BOTH));
            cap_step(i, 16'h0100 + 16'(i), 1'b1, 16'h0100 + 16'(i));
            wr(cc_pkg::A_EN, 32'h1 << i);
            rd_chk(cc_pkg::A_VEC, {15'h0, 1'b1, 8'h10 + 8'(i), 8'h40 + 8'(4 * i)});
            chk32({16'h0, irq_trap, irq_vector}, {16'h0, 8'h10 + 8'(i), 8'h40 + 8'(4 * i)});
            wr(cc_pkg::A_EN, 32'h0);
            cap_step(i, 16'h0200, 1'b0, 16'h0200);
            wr(cfg_a(i), 32'h0);
        end
        wr(cfg_a(5), 32'(cc_pkg::CAP_RISE));
        cap_step(5, 16'h0333, 1'b1, 16'h0333);
        cap_step(5, 16'h0344, 1'b0, 16'h0333);
        wr(cfg_a(4), 32'(cc_pkg::CAP_FALL));
        cap_step(4, 16'h0355, 1'b1, 16'h0200);
        cap_step(4, 16'h0366, 1'b0, 16'h0366);
        wr(cfg_a(4), 32'h0);
        wr(cfg_a(5), 32'h0);
        // compare modes and one paired pin, all on time base a
        wr(cc_pkg::A_DBL, 32'h4);
        for (int k = 0; k < 6; k++) begin
            wr(cfg_a(cmp_ch[k]), 32'(cmp_md[k]));
            wr(val_a(cmp_ch[k]), (k == 5) ? 32'h11 : 32'h10);
        end
        wr(cc_pkg::A_REQ, 32'h3FFFF);
        wr(cc_pkg::A_CNT_A, 32'hF);
        pins_u.ext_pulse();
        bus_rd(cc_pkg::A_REQ, d, r);
        chk32(d & 32'hC1, 32'hC1);
        chk1(cc_pin_out[0], 1'b0);
        chk1(cc_pin_out[1], 1'b1);
        chk1(cc_pin_out[7], 1'b1);
        chk1(cc_pin_out[2], 1'b1);
        chk1(cc_pin_oe[10], 1'b0);
        pins_u.ext_pulse();
        chk1(cc_pin_out[2], 1'b0);
        // same period again: repeatable modes fire, one-shot modes stay quiet
        wr(cc_pkg::A_REQ, 32'h3FFFF);
        wr(cc_pkg::A_CNT_A, 32'hF);
        pins_u.ext_pulse();
        bus_rd(cc_pkg::A_REQ, d, r);
        chk32(d & 32'hC1, 32'h01);
        chk1(cc_pin_out[1], 1'b0);
        chk1(cc_pin_out[2], 1'b1);
        chk1(cc_pin_out[7], 1'b1);
        wr(cc_pkg::A_CNT_A, 32'hFFFF);
        pins_u.ext_pulse();
        chk1(cc_pin_out[7], 1'b0);
        // new period after the overflow rearms the one-shot modes
        wr(cc_pkg::A_REQ, 32'h3FFFF);
        wr(cc_pkg::A_CNT_A, 32'hF);
        pins_u.ext_pulse();
        bus_rd(cc_pkg::A_REQ, d, r);
        chk32(d & 32'hC1, 32'hC1);
        chk1(cc_pin_out[7], 1'b1);
        // finest step on a, next step on b: one tick per eight and sixteen clocks
        wr(cc_pkg::A_TBCTL, 32'h98);
        bus_rd(cc_pkg::A_CNT_A, d, r);
        bus_rd(cc_pkg::A_CNT_B, d3, r);
        repeat (128) @(posedge ref_clk);
        bus_rd(cc_pkg::A_CNT_A, d2, r);
        bus_rd(cc_pkg::A_CNT_B, d4, r);
        chk1((d2 - d) inside {32'h10, 32'h11}, 1'b1);
        chk1((d4 - d3) inside {32'h8, 32'h9}, 1'b1);
        give_verdict();
    end
endmodule: sixteen_channel_capture_compare_tb_top
